// *** design/uab_top.sv ***
// Purpose: Serial port slice: rate generator, rate measurement, async transmitter
// Assumes: AHB-Lite single word transfers; sys_clk_i is the oscillator clock
// Notes:   Receiver data path is not part of this slice
//
// Decided for this implementation: the register addresses and the AHB-Lite slave port.
`timescale 1ns/10ps
`include "uab_cfg.svh"

module uab_top (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Serial line
  input  wire logic        rx_i,
  output logic             tx_o,
  // Status
  output logic             tx_buffer_empty_flag_o,
  output logic             receive_flag_o
);

  uab_pkg::uab_state_s s_r;
  uab_pkg::uab_state_s s_nxt;

  logic        rx_level;
  logic        rx_rise;
  logic        rx_fall;
  logic [9:0]  pre_base;
  logic [8:0]  pre_lim;
  logic        pre_hit;
  logic [15:0] div_val;
  logic [15:0] div_cnt;
  logic        ab_busy;
  logic        ab_counting;
  logic        baud_tick;
  logic        addr_ok;
  logic        wr_go;
  logic [7:0]  wbyte;
  logic [7:0]  rbyte;
  logic [10:0] frame;
  logic        hs_unused;

  // ========================================================================
  // Receive line conditioning
  uab_rx_filter u_rx_filter (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .rx_i      (rx_i),
    .rx_o      (rx_level)
  );

  assign rx_rise = rx_level & ~s_r.rx_prev;
  assign rx_fall = ~rx_level & s_r.rx_prev;

  // ========================================================================
  // Rate generator helpers
  always_comb begin
    case ({s_r.wide_divisor_enable, s_r.high_speed_rate})
      2'b00:   pre_base = 10'(`UAB_PRE_X64);
      2'b01:   pre_base = 10'(`UAB_PRE_X16);
      2'b10:   pre_base = 10'(`UAB_PRE_X16);
      default: pre_base = 10'(`UAB_PRE_X4);
    endcase
  end

  assign ab_busy     = (s_r.ab_st != uab_pkg::UAB_AB_IDLE);
  assign ab_counting = (s_r.ab_st == uab_pkg::UAB_AB_COUNT);
  // Measurement slows the prescaler eight times
  assign pre_lim     = ab_counting ? 9'((pre_base * 10'(`UAB_ABD_SLOW)) - 10'd1)
                                   : 9'(pre_base - 10'd1);
  assign pre_hit     = (s_r.pre == pre_lim);
  assign div_val     = s_r.wide_divisor_enable ? {s_r.baud_divisor_high, s_r.baud_divisor_low}
                                               : {8'h00, s_r.baud_divisor_low};
  assign div_cnt     = {s_r.baud_divisor_high, s_r.baud_divisor_low};
  assign baud_tick   = ~ab_busy & pre_hit & (s_r.bcnt == div_val);

  // ========================================================================
  // Bus helpers
  assign addr_ok   = hsel_i & htrans_i[1] & hready_i;
  assign wr_go     = s_r.dp.valid & s_r.dp.write;
  assign wbyte     = hwdata_i[7:0];
  assign hs_unused = |hsize_i;

  always_comb begin
    rbyte = 8'h00;
    case (haddr_i[7:0])
      `UAB_OFS_TXSC: begin
        rbyte[`UAB_TXSC_NINE]  = s_r.nine_bit_tx;
        rbyte[`UAB_TXSC_TE]    = s_r.transmit_enable;
        rbyte[`UAB_TXSC_SYNC]  = s_r.sync_mode;
        rbyte[`UAB_TXSC_HS]    = s_r.high_speed_rate;
        rbyte[`UAB_TXSC_SE]    = (s_r.tx_st == uab_pkg::UAB_TX_IDLE);
        rbyte[`UAB_TXSC_NINTH] = s_r.tx_ninth_bit;
      end
      `UAB_OFS_RXSC: begin
        rbyte[`UAB_RXSC_PEN] = s_r.port_enable;
      end
      `UAB_OFS_BAUDC: begin
        rbyte[`UAB_BC_OVF]  = s_r.autobaud_overflow;
        rbyte[`UAB_BC_IDLE] = ~ab_busy;
        rbyte[`UAB_BC_WIDE] = s_r.wide_divisor_enable;
        rbyte[`UAB_BC_WUE]  = s_r.wake_on_edge_enable;
        rbyte[`UAB_BC_ABEN] = s_r.autobaud_enable;
      end
      `UAB_OFS_TXBUF: rbyte = s_r.transmit_buffer;
      `UAB_OFS_DIVH:  rbyte = s_r.baud_divisor_high;
      `UAB_OFS_DIVL:  rbyte = s_r.baud_divisor_low;
      // Receive data is meaningless in this slice
      `UAB_OFS_RXBUF: rbyte = 8'h00;
      `UAB_OFS_FLAGS: begin
        rbyte[`UAB_FL_TXE]  = s_r.tx_flag;
        rbyte[`UAB_FL_RXF]  = s_r.receive_flag;
        rbyte[`UAB_FL_TXIE] = s_r.tx_buffer_empty_irq_en;
      end
      default: rbyte = 8'h00;
    endcase
  end

  // Frame image, start bit at bit 0
  assign frame = {1'b1, (s_r.nine_bit_tx ? s_r.tx_ninth_bit : 1'b1),
                  s_r.transmit_buffer, 1'b0};

  // ========================================================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    if (!rst_b_i) begin
      s_nxt           = '0;
      s_nxt.tx_st     = uab_pkg::UAB_TX_IDLE;
      s_nxt.ab_st     = uab_pkg::UAB_AB_IDLE;
      s_nxt.tx_line   = `UAB_RST_LINE;
      s_nxt.rx_prev   = `UAB_RST_LINE;
      s_nxt.hreadyout = `UAB_RST_HREADY;
    end else begin
      s_nxt.rx_prev   = rx_level;
      s_nxt.hreadyout = 1'b1;

      // Address phase: capture, read data, read side effects
      s_nxt.dp.valid = addr_ok;
      s_nxt.dp.write = hwrite_i;
      s_nxt.dp.addr  = haddr_i[7:0];
      if (addr_ok && !hwrite_i) begin
        s_nxt.hrdata = {24'h00_0000, rbyte};
        if (haddr_i[7:0] == `UAB_OFS_RXBUF) begin
          s_nxt.receive_flag = 1'b0;
        end
      end

      // Rate generator
      if (pre_hit) begin
        s_nxt.pre = 9'h000;
        if (ab_counting) begin
          {s_nxt.baud_divisor_high, s_nxt.baud_divisor_low} = div_cnt + 16'h0001;
        end else if (!ab_busy) begin
          s_nxt.bcnt = (s_r.bcnt == div_val) ? 16'h0000 : s_r.bcnt + 16'h0001;
        end
      end else begin
        s_nxt.pre = s_r.pre + 9'h001;
      end

      // Data phase writes
      if (wr_go) begin
        case (s_r.dp.addr)
          `UAB_OFS_TXSC: begin
            s_nxt.nine_bit_tx     = wbyte[`UAB_TXSC_NINE];
            s_nxt.transmit_enable = wbyte[`UAB_TXSC_TE];
            s_nxt.sync_mode       = wbyte[`UAB_TXSC_SYNC];
            s_nxt.high_speed_rate = wbyte[`UAB_TXSC_HS];
            s_nxt.tx_ninth_bit    = wbyte[`UAB_TXSC_NINTH];
          end
          `UAB_OFS_RXSC: s_nxt.port_enable = wbyte[`UAB_RXSC_PEN];
          `UAB_OFS_BAUDC: begin
            s_nxt.autobaud_overflow   = wbyte[`UAB_BC_OVF];
            s_nxt.wide_divisor_enable = wbyte[`UAB_BC_WIDE];
            s_nxt.wake_on_edge_enable = wbyte[`UAB_BC_WUE];
            s_nxt.autobaud_enable     = wbyte[`UAB_BC_ABEN];
            if (!wbyte[`UAB_BC_WUE]) begin
              s_nxt.wake_low = 1'b0;
            end
            if (wbyte[`UAB_BC_ABEN] && !s_r.autobaud_enable) begin
              s_nxt.baud_divisor_high = 8'h00;
              s_nxt.baud_divisor_low  = 8'h00;
              s_nxt.ab_st             = uab_pkg::UAB_AB_START;
              s_nxt.pre               = 9'h000;
              s_nxt.bcnt              = 16'h0000;
            end else if (!wbyte[`UAB_BC_ABEN]) begin
              s_nxt.ab_st = uab_pkg::UAB_AB_IDLE;
            end
          end
          `UAB_OFS_TXBUF: begin
            s_nxt.transmit_buffer = wbyte;
            s_nxt.buf_full        = 1'b1;
            s_nxt.lag             = 4'(`UAB_FLAG_LAG_CLKS - 1);
          end
          `UAB_OFS_DIVH: begin
            s_nxt.baud_divisor_high = wbyte;
            s_nxt.pre               = 9'h000;
            s_nxt.bcnt              = 16'h0000;
          end
          `UAB_OFS_DIVL: begin
            s_nxt.baud_divisor_low = wbyte;
            s_nxt.pre              = 9'h000;
            s_nxt.bcnt             = 16'h0000;
          end
          `UAB_OFS_FLAGS: s_nxt.tx_buffer_empty_irq_en = wbyte[`UAB_FL_TXIE];
          default: ;
        endcase
      end

      // Counter wrap is trapped after any software write so the set wins
      if (ab_counting && pre_hit && (div_cnt == 16'hFFFF)) begin
        s_nxt.autobaud_overflow = 1'b1;
      end

      // Wake on edge: flag at the break's falling edge, release at its rising edge
      if (s_r.wake_on_edge_enable && s_r.port_enable && !s_r.sync_mode) begin
        if (!s_r.wake_low && rx_fall) begin
          s_nxt.wake_low     = 1'b1;
          s_nxt.receive_flag = 1'b1;
        end else if (s_r.wake_low && rx_rise) begin
          s_nxt.wake_low            = 1'b0;
          s_nxt.wake_on_edge_enable = 1'b0;
        end
      end

      // Rate measurement
      case (s_r.ab_st)
        uab_pkg::UAB_AB_IDLE: ;
        uab_pkg::UAB_AB_START: begin
          if (s_r.port_enable && !s_r.sync_mode && !s_r.wake_on_edge_enable &&
              rx_fall) begin
            s_nxt.ab_st = uab_pkg::UAB_AB_RISE;
          end
        end
        uab_pkg::UAB_AB_RISE: begin
          if (rx_rise) begin
            s_nxt.ab_st = uab_pkg::UAB_AB_COUNT;
            s_nxt.edges = 3'd1;
            s_nxt.pre   = 9'h000;
          end
        end
        uab_pkg::UAB_AB_COUNT: begin
          if (rx_rise) begin
            if (s_r.edges == 3'(`UAB_ABD_EDGES - 1)) begin
              s_nxt.ab_st           = uab_pkg::UAB_AB_IDLE;
              s_nxt.autobaud_enable = 1'b0;
              s_nxt.receive_flag    = 1'b1;
              s_nxt.pre             = 9'h000;
              s_nxt.bcnt            = 16'h0000;
            end else begin
              s_nxt.edges = s_r.edges + 3'd1;
            end
          end
        end
        default: s_nxt.ab_st = uab_pkg::UAB_AB_IDLE;
      endcase

      // Transmitter
      case (s_r.tx_st)
        uab_pkg::UAB_TX_IDLE: begin
          s_nxt.tx_line = 1'b1;
          if (s_r.buf_full && s_r.transmit_enable && s_r.port_enable &&
              !s_r.sync_mode && !ab_busy) begin
            s_nxt.tx_st  = uab_pkg::UAB_TX_LOAD;
            s_nxt.ld_cnt = 4'(`UAB_INSTR_CLKS - 1);
          end
        end
        uab_pkg::UAB_TX_LOAD: begin
          if (s_r.ld_cnt == 4'h0) begin
            s_nxt.shifter   = {1'b1, frame[10:1]};
            s_nxt.tx_line   = frame[0];
            s_nxt.bits_left = s_r.nine_bit_tx ? 4'd10 : 4'd9;
            s_nxt.buf_full  = 1'b0;
            s_nxt.tx_st     = uab_pkg::UAB_TX_SHIFT;
            s_nxt.pre       = 9'h000;
            s_nxt.bcnt      = 16'h0000;
          end else begin
            s_nxt.ld_cnt = s_r.ld_cnt - 4'h1;
          end
        end
        uab_pkg::UAB_TX_SHIFT: begin
          if (baud_tick) begin
            if (s_r.bits_left == 4'h0) begin
              s_nxt.tx_st = uab_pkg::UAB_TX_IDLE;
            end else begin
              s_nxt.tx_line   = s_r.shifter[0];
              s_nxt.shifter   = {1'b1, s_r.shifter[10:1]};
              s_nxt.bits_left = s_r.bits_left - 4'h1;
            end
          end
        end
        default: s_nxt.tx_st = uab_pkg::UAB_TX_IDLE;
      endcase
      // Disabling the transmitter aborts the frame and frees the line
      if (!s_r.transmit_enable || !s_r.port_enable) begin
        s_nxt.tx_st   = uab_pkg::UAB_TX_IDLE;
        s_nxt.tx_line = 1'b1;
      end

      // Buffer-empty flag follows the buffer only after the write lag
      if (s_r.lag != 4'h0) begin
        s_nxt.lag = s_r.lag - 4'h1;
      end else begin
        s_nxt.tx_flag = s_r.transmit_enable & ~s_r.buf_full;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    s_r <= s_nxt;
  end

  // ========================================================================
  // Outputs, all from flip-flops except hresp_o, which is tied low
  assign hrdata_o               = s_r.hrdata;
  assign hreadyout_o            = s_r.hreadyout;
  assign hresp_o                = s_r.dp.valid & 1'b0 & hs_unused;
  assign tx_o                   = s_r.tx_line;
  assign tx_buffer_empty_flag_o = s_r.tx_flag;
  assign receive_flag_o         = s_r.receive_flag;

endmodule // uab_top

// *** design/uab_cfg.svh ***
// Purpose: Offsets, field positions, reset values and timing counts of the serial port slice
// Assumes: Included by its bare name from design files
// Notes:   Definitions only
`ifndef UAB_CFG_SVH
`define UAB_CFG_SVH

// ==========================================================================
// Register byte offsets
`define UAB_OFS_TXSC        8'h00
`define UAB_OFS_RXSC        8'h04
`define UAB_OFS_BAUDC       8'h08
`define UAB_OFS_TXBUF       8'h0C
`define UAB_OFS_DIVH        8'h10
`define UAB_OFS_DIVL        8'h14
`define UAB_OFS_RXBUF       8'h18
`define UAB_OFS_FLAGS       8'h1C

// ==========================================================================
// Field positions
`define UAB_TXSC_NINE       6
`define UAB_TXSC_TE         5
`define UAB_TXSC_SYNC       4
`define UAB_TXSC_HS         2
`define UAB_TXSC_SE         1
`define UAB_TXSC_NINTH      0
`define UAB_RXSC_PEN        7
`define UAB_BC_OVF          7
`define UAB_BC_IDLE         6
`define UAB_BC_WIDE         3
`define UAB_BC_WUE          1
`define UAB_BC_ABEN         0
`define UAB_FL_TXE          0
`define UAB_FL_RXF          1
`define UAB_FL_TXIE         2

// ==========================================================================
// Reset values
`define UAB_RST_LINE        1'b1
`define UAB_RST_HREADY      1'b1

// ==========================================================================
// Timing
`define UAB_CLK_PERIOD_NS   8
`define UAB_INSTR_CYCLE_NS  32
`define UAB_INSTR_CLKS      ((`UAB_INSTR_CYCLE_NS + `UAB_CLK_PERIOD_NS - 1) / `UAB_CLK_PERIOD_NS)
`define UAB_FLAG_LAG_CLKS   (2 * `UAB_INSTR_CLKS)
`define UAB_PRE_X64         64
`define UAB_PRE_X16         16
`define UAB_PRE_X4          4
`define UAB_ABD_SLOW        8
`define UAB_ABD_EDGES       5

`endif

// *** design/uab_pkg.sv ***
// Purpose: Types shared by the serial port slice
// Assumes: Constants come from uab_cfg.svh
// Notes:   Holds types only
package uab_pkg;

  // ========================================================================
  // State machines
  typedef enum logic [2:0] {
    UAB_TX_IDLE  = 3'b001,
    UAB_TX_LOAD  = 3'b010,
    UAB_TX_SHIFT = 3'b100
  } uab_tx_e;

  typedef enum logic [3:0] {
    UAB_AB_IDLE  = 4'b0001,
    UAB_AB_START = 4'b0010,
    UAB_AB_RISE  = 4'b0100,
    UAB_AB_COUNT = 4'b1000
  } uab_ab_e;

  // ========================================================================
  // Carriers
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } uab_dphase_s;

  typedef struct packed {
    logic [1:0] sync;
    logic [2:0] hist;
    logic       level;
  } uab_filt_s;

  typedef struct packed {
    logic        nine_bit_tx;
    logic        transmit_enable;
    logic        sync_mode;
    logic        high_speed_rate;
    logic        tx_ninth_bit;
    logic        port_enable;
    logic        autobaud_overflow;
    logic        wide_divisor_enable;
    logic        wake_on_edge_enable;
    logic        autobaud_enable;
    logic        tx_buffer_empty_irq_en;
    logic [7:0]  baud_divisor_high;
    logic [7:0]  baud_divisor_low;
    logic [7:0]  transmit_buffer;
    logic        buf_full;
    logic        tx_flag;
    logic        receive_flag;
    logic [3:0]  lag;
    uab_tx_e     tx_st;
    logic [3:0]  ld_cnt;
    logic [10:0] shifter;
    logic [3:0]  bits_left;
    logic        tx_line;
    uab_ab_e     ab_st;
    logic [2:0]  edges;
    logic        wake_low;
    logic        rx_prev;
    logic [8:0]  pre;
    logic [15:0] bcnt;
    uab_dphase_s dp;
    logic [31:0] hrdata;
    logic        hreadyout;
  } uab_state_s;

endpackage

// *** design/uab_rx_filter.sv ***
// Purpose: Receive line synchroniser and three-sample majority vote
// Assumes: Line idles high
// Notes:   Output is registered
`timescale 1ns/10ps
`include "uab_cfg.svh"

module uab_rx_filter (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_b_i,
  // Line
  input  wire logic rx_i,
  output logic      rx_o
);

  uab_pkg::uab_filt_s s_r;
  uab_pkg::uab_filt_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (!rst_b_i) begin
      s_nxt = '1;
    end else begin
      s_nxt.sync  = {s_r.sync[0], rx_i};
      s_nxt.hist  = {s_r.hist[1:0], s_r.sync[1]};
      s_nxt.level = (s_r.hist[0] & s_r.hist[1]) | (s_r.hist[1] & s_r.hist[2]) |
                    (s_r.hist[0] & s_r.hist[2]);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    s_r <= s_nxt;
  end

  assign rx_o = s_r.level;

endmodule // uab_rx_filter

// *** test/uab_asserts.sv ***
// Purpose: Port-level checks for the serial port slice
// Assumes: Bound to uab_top, one clock domain
// Notes:   Sees only the top module ports
`timescale 1ns/10ps

module uab_asserts (
  // Clock and reset
  input wire logic        sys_clk_i,
  input wire logic        rst_b_i,
  // Bus
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic [2:0]  hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  // Line and status
  input wire logic        rx_i,
  input wire logic        tx_o,
  input wire logic        tx_buffer_empty_flag_o,
  input wire logic        receive_flag_o
);
  logic take;
  logic wr_tx;
  logic rd_any;
  logic rd_rxb;
  logic te_dp;
  logic te_seen;

  assign take   = hsel_i && htrans_i[1] && hready_i;
  assign wr_tx  = take && hwrite_i && (haddr_i[7:0] == 8'h0C);
  assign rd_any = take && !hwrite_i;
  assign rd_rxb = rd_any && (haddr_i[7:0] == 8'h18);

  // Copy of the transmit enable bit, to tell an enable rise from a load rise
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      te_dp   <= 1'b0;
      te_seen <= 1'b0;
    end else begin
      te_dp <= take && hwrite_i && (haddr_i[7:0] == 8'h00);
      if (te_dp) begin
        te_seen <= hwdata_i[5];
      end
    end
  end

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  // ========================================================================
  // Bus
  a_zero_wait: assert property (hreadyout_o) else $error("slave inserted a wait");
  a_resp_okay: assert property (hresp_o == 1'b0) else $error("slave gave an error response");
  a_rdata_upper: assert property (hrdata_o[31:8] == 24'h0) else $error("upper read bits set");
  a_rdata_hold: assert property (!$past(rd_any) |-> $stable(hrdata_o))
    else $error("read data moved without a read");

  // ========================================================================
  // Transmitter and receive flag
  // Shortest bit is four clocks, so a start bit never lasts less
  a_start_hold: assert property ($fell(tx_o) |-> !tx_o [*4])
    else $error("start bit too short");
  a_flag_lag: assert property (wr_tx |=> ##1 $stable(tx_buffer_empty_flag_o) [*4])
    else $error("empty flag moved too soon after a buffer write");
  // Data-bit falls also occur while a byte waits, so key on the flag rising instead
  a_flag_at_load: assert property (
    $rose(tx_buffer_empty_flag_o) && $past(te_seen, 2) |-> !tx_o)
    else $error("empty flag rose without a shifter load");
  a_rxflag_clear: assert property (rd_rxb |-> ##[1:2] !receive_flag_o)
    else $error("receive flag not cleared by buffer read");
endmodule // uab_asserts

bind uab_top uab_asserts i_chk (
  .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
  .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .rx_i(rx_i), .tx_o(tx_o), .tx_buffer_empty_flag_o(tx_buffer_empty_flag_o),
  .receive_flag_o(receive_flag_o));

// *** test/uab_remote.sv ***
// Purpose: Remote serial node: sends characters, decodes frames of the slice
// Assumes: Bit time in clocks is set by the bench
// Notes:   Line idles high as if pulled up
`timescale 1ns/10ps

module uab_remote (
  // Clock
  input  wire logic clk_i,
  // Lines
  input  wire logic line_i,
  output logic      line_o
);
  int   bit_clks = 16;
  logic nine     = 1'b0;
  int   rx_q[$];

  initial line_o = 1'b1;

  // ========================================================================
  // Sender: start low, data LSB first, stop high
  task automatic send_char(input logic [7:0] d, input int clks);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_o <= f[i];
      repeat (clks) @(posedge clk_i);
    end
  endtask

  // ========================================================================
  // Decoder: mid-bit samples; a low stop is stored as -1
  always begin : decode
    logic [8:0] v;
    @(negedge line_i);
    v = '0;
    repeat (bit_clks / 2) @(posedge clk_i);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      repeat (bit_clks) @(posedge clk_i);
      v[i] = line_i;
    end
    repeat (bit_clks) @(posedge clk_i);
    rx_q.push_back(line_i ? int'(v) : -1);
  end
endmodule // uab_remote

// *** test/testbench.sv ***
// Purpose: Self-checking bench for the serial port slice
// Assumes: Zero-wait AHB-Lite slave, remote node on the line
// Notes:   Expected frames kept in a queue and compared per character
`timescale 1ns/10ps

module testbench;
  // ========================================================================
  // Signals
  logic        clk         = 1'b0;
  logic        rst_b       = 1'b0;
  logic        hsel        = 1'b0;
  logic [31:0] haddr       = 32'h0000_0000;
  logic [1:0]  htrans      = 2'b00;
  logic        hwrite      = 1'b0;
  logic [2:0]  hsize       = 3'b010;
  logic [31:0] hwdata      = 32'h0000_0000;
  logic        hready;
  logic [31:0] hrdata;
  logic        hresp;
  logic        rx;
  logic        tx;
  logic        txe_flag;
  logic        rx_flag;
  logic [31:0] rd;
  logic [31:0] cnt;
  logic [7:0]  cfg;
  logic [7:0]  dat;
  int          miscompares = 0;
  int          checks_done = 0;
  int          seed        = 42214;
  int          dv;
  int          pb;
  int          exp_q[$];
  logic [7:0]  ofs [9]   = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
  logic [7:0]  rst_v [9] = '{8'h02, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  uab_top i_dut (
    .sys_clk_i(clk), .rst_b_i(rst_b), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .rx_i(rx), .tx_o(tx),
    .tx_buffer_empty_flag_o(txe_flag), .receive_flag_o(rx_flag));

  uab_remote i_remote (.clk_i(clk), .line_i(tx), .line_o(rx));

  always #4 clk = ~clk;

  // ========================================================================
  // Helpers
  function automatic int xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task report_and_stop();
    if (miscompares == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // One single transfer; waits on hready, never on a fixed latency
  task xfer(input logic [7:0] a, input logic w, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 64);
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 64);
    rd = hrdata;
    if (n >= 64) begin
      check(32'h0, 32'h1);
      report_and_stop();
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 8'h00);
    check(rd, e);
  endtask

  task wait_rx(input int k);
    int n;
    n = 0;
    while (i_remote.rx_q.size() < k && n < 60000) begin @(posedge clk); n++; end
    if (n >= 60000) begin
      check(32'h0, 32'h1);
      report_and_stop();
    end
  endtask

  // ========================================================================
  // Sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    foreach (ofs[i]) rdc(ofs[i], {24'h0, rst_v[i]});
    wr(8'h08, 8'h80);
    rdc(8'h08, 32'h0000_00C0);
    wr(8'h08, 8'h00);
    rdc(8'h08, 32'h0000_0040);
    wr(8'h20, 8'hFF);
    rdc(8'h20, 32'h0000_0000);
    wr(8'h04, 8'h80);
    check({31'h0, txe_flag}, 32'h0);
    wr(8'h00, 8'h20);
    repeat (4) @(posedge clk);
    check({31'h0, txe_flag}, 32'h1);
    wr(8'h1C, 8'h04);
    rdc(8'h1C, 32'h0000_0005);
    // Every speed setting; high byte set but ignored in 8-bit modes
    for (int m = 0; m < 4; m++) begin
      dv = 1 + (xs() & 3);
      pb = (dv + 1) * ((m == 0) ? 64 : (m == 3) ? 4 : 16);
      i_remote.bit_clks = pb;
      i_remote.nine = (m == 3);
      cfg = 8'h20 | ((m == 3) ? 8'h40 : 8'h00) | (m[0] ? 8'h04 : 8'h00) | 8'(xs() & 1);
      wr(8'h14, 8'(dv));
      wr(8'h10, (m < 2) ? 8'h01 : 8'h00);
      wr(8'h08, (m > 1) ? 8'h08 : 8'h00);
      wr(8'h00, cfg);
      // Second byte lands while the first is still shifting
      for (int k = 0; k < 2; k++) begin
        dat = 8'(xs());
        exp_q.push_back({(m == 3) & cfg[0], dat});
        wr(8'h0C, dat);
        repeat (8) @(posedge clk);
      end
      rdc(8'h00, {24'h0, cfg});
      wait_rx(2);
      repeat (pb) @(posedge clk);
      rdc(8'h00, {24'h0, cfg | 8'h02});
      while (i_remote.rx_q.size() > 0) begin
        check(i_remote.rx_q.pop_front(), exp_q.pop_front());
      end
    end
    // Rate measurement, counter clock eight times slower than the prescaler clock
    // Transmitter idle here; last pass arms wake-on-edge and sends a break first
    for (int k = 0; k < 3; k++) begin
      pb = (k == 1) ? 16 : 4;
      wr(8'h00, (k == 1) ? 8'h20 : 8'h24);
      wr(8'h08, (k == 2) ? 8'h0B : 8'h09);
      rdc(8'h14, 32'h0000_0000);
      rdc(8'h10, 32'h0000_0000);
      if (k == 2) begin
        i_remote.send_char(8'h00, 32 * pb);
        check({31'h0, rx_flag}, 32'h1);
      end
      i_remote.send_char(8'h55, 32 * pb);
      check({31'h0, rx_flag}, 32'h1);
      rdc(8'h08, 32'h0000_0048);
      xfer(8'h14, 1'b0, 8'h00);
      cnt = rd;
      xfer(8'h10, 1'b0, 8'h00);
      cnt = cnt | (rd << 8);
      check({31'h0, cnt >= 31 && cnt <= 33}, 32'h1);
      rdc(8'h18, 32'h0000_0000);
      repeat (2) @(posedge clk);
      check({31'h0, rx_flag}, 32'h0);
    end
    // Sync mode keeps the byte in the buffer and the line idle
    wr(8'h00, 8'h30);
    wr(8'h0C, 8'hA5);
    repeat (16) @(posedge clk);
    check({31'h0, tx}, 32'h1);
    check({31'h0, txe_flag}, 32'h0);
    rdc(8'h00, 32'h0000_0032);
    report_and_stop();
  end
endmodule // testbench
